// *** inc/fesm_div_if.sv ***
// fesm_div_if: request and answer of the shared divider.
// assumes the requester holds num and den stable until done.
`timescale 1ns/1ps
interface fesm_div_if #(parameter int NW = 80, parameter int DW = 48);
	logic start;
	logic [NW-1:0] num;
	logic [DW-1:0] den;
	logic done;
	logic [NW-1:0] quo;
	modport req(output start, output num, output den, input done, input quo);
	modport srv(input start, input num, input den, output done, output quo);
endinterface

// *** inc/fesm_pkg.sv ***
// fesm_pkg: shared constants, register map and state codes of the FEC error statistics monitor.
// assumes a 200 MHz system clock and a 32-bit register port with 8-bit word addresses.
package fesm_pkg;
	// clock and sampling interval
	localparam int CLK_MHZ = 200;
	localparam int SAMPLE_US = 1000;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
	// widths
	localparam int RW = 32;
	localparam int ACC_W = 48;
	localparam int DIV_NW = 80;
	localparam int BER_FRAC = 32;
	localparam int UNCORRECTABLE_FRAME_COUNT_FRAC = 8;
	localparam int LOG_FRAC = 8;
	// reference frame size in bits, reset of the frame size register
	localparam logic [15:0] REF_FRAME_BITS = 16'h1540;
	// level transition codes and dB scale
	localparam logic [15:0] LTP_INF = 16'hFFFF;
	localparam logic [15:0] LTP_OVR = 16'hFFFE;
	localparam logic [15:0] DB_PER_LOG2 = 16'h0303;
	// register word addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FRAME_BITS = 8'h01;
	localparam logic [7:0] A_INTERVAL = 8'h02;
	localparam logic [7:0] A_LTP = 8'h03;
	localparam logic [7:0] A_BER_CUR = 8'h04;
	localparam logic [7:0] A_BER_MIN = 8'h05;
	localparam logic [7:0] A_BER_MAX = 8'h06;
	localparam logic [7:0] A_BER_AVG = 8'h07;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_CUR = 8'h08;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_MIN = 8'h09;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_MAX = 8'h0A;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_AVG = 8'h0B;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_TOT = 8'h0C;
	localparam logic [7:0] A_BER_THR_HI = 8'h0D;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_THR_HI = 8'h0E;
	localparam logic [7:0] A_BER_THR_LO = 8'h0F;
	localparam logic [7:0] A_UNCORRECTABLE_FRAME_COUNT_THR_LO = 8'h10;
	// control fields
	localparam int CTRL_FREEZE = 0;
	localparam int CTRL_FROZEN = 1;
	localparam int CTRL_BUSY = 2;
	// threshold reset values
	localparam logic [31:0] BER_THR_HI_RST = 32'h0010_0000;
	localparam logic [31:0] UNCORRECTABLE_FRAME_COUNT_THR_HI_RST = 32'h0000_0000;
	localparam logic [31:0] THR_LO = 32'h0000_0000;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_FSCALE = 6'b000010,
		ST_BSAMP = 6'b000100,
		ST_UPD = 6'b001000,
		ST_BAVG = 6'b010000,
		ST_FAVG = 6'b100000
	} fesm_state_e;
endpackage

// *** logic/fesm_div.sv ***
// fesm_div: restoring divider, one quotient bit per clock.
// assumes one start pulse per job; divide by zero yields all ones.
`timescale 1ns/1ps
module fesm_div import fesm_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// job port
	fesm_div_if.srv d
);
	localparam int NW = $bits(d.num);
	localparam int DW = $bits(d.den);
	localparam int CW = $clog2(NW + 1);
	logic [NW-1:0] q_q;
	logic [DW:0] r_q;
	logic [CW-1:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [DW:0] t;
	assign t = {r_q[DW-1:0], q_q[NW-1]};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q_q <= '0;
			r_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (d.start) begin
				q_q <= d.num;
				r_q <= '0;
				cnt_q <= CW'(NW);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (t >= {1'b0, d.den}) begin
					r_q <= t - {1'b0, d.den};
					q_q <= {q_q[NW-2:0], 1'b1};
				end else begin
					r_q <= t;
					q_q <= {q_q[NW-2:0], 1'b0};
				end
				cnt_q <= cnt_q - CW'(1);
				if (cnt_q == CW'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
	assign d.quo = q_q;
	assign d.done = done_q;
endmodule // fesm_div

// *** logic/fesm_ltp_enc.sv ***
// fesm_ltp_enc: level transition parameter from peak and valley heights of a 4-level histogram.
// assumes histogram heights on the same clock, taken when hist_valid pulses.
`timescale 1ns/1ps
module fesm_ltp_enc import fesm_pkg::*; #(parameter int HW = 16) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// histogram
	input wire logic hist_valid,
	input wire logic [4*HW-1:0] peaks,
	input wire logic [3*HW-1:0] valleys,
	// encoded value
	output logic [15:0] ltp_code
);
	localparam int LW = 16;
	localparam int DBW = 27;
	// log2 in Q8: msb position plus the next eight bits as linear mantissa
	function automatic logic [LW-1:0] log2q(input logic [HW:0] x);
		logic [HW:0] n;
		logic [LW-1:0] e;
		n = '0;
		e = '0;
		for (int i = 0; i <= HW; i++) begin
			if (x[i]) begin
				e = LW'(i);
				n = x << (HW - i);
			end
		end
		return (e << LOG_FRAC) | LW'(n[HW-1 -: LOG_FRAC]);
	endfunction
	logic zero;
	logic signed [LW:0] diff;
	logic signed [LW:0] dmin;
	logic [HW:0] psum;
	logic [HW:0] vdbl;
	logic [DBW-1:0] db;
	logic [15:0] ltp_q;
	always_comb begin
		zero = 1'b0;
		dmin = {1'b0, {LW{1'b1}}};
		diff = '0;
		psum = '0;
		vdbl = '0;
		for (int i = 0; i < 3; i++) begin
			psum = {1'b0, peaks[i*HW +: HW]} + {1'b0, peaks[(i+1)*HW +: HW]};
			vdbl = {valleys[i*HW +: HW], 1'b0};
			if (valleys[i*HW +: HW] == '0) begin
				zero = 1'b1;
			end
			// ratio mean(P_i,P_i+1)/V_i in log form: log(P_i+P_i+1) - log(2V_i)
			diff = $signed({1'b0, log2q(psum)}) - $signed({1'b0, log2q(vdbl)});
			if (diff < dmin) begin
				dmin = diff;
			end
		end
		// ratio below one has no unsigned code, floor it at zero
		if (dmin < 0) begin
			db = '0;
		end else begin
			db = (DBW'(dmin[LW-1:0]) * DBW'(DB_PER_LOG2)) >> LOG_FRAC;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ltp_q <= '0;
		end else if (hist_valid) begin
			if (zero) begin
				ltp_q <= LTP_INF;
			end else if (db >= DBW'(LTP_OVR)) begin
				ltp_q <= LTP_OVR;
			end else begin
				ltp_q <= db[15:0];
			end
		end
	end
	assign ltp_code = ltp_q;
	a_ltp_zero_code: assert property (@(posedge sys_clk) disable iff (rst)
		hist_valid && zero |=> ltp_q == LTP_INF)
		else $error("zero valley not encoded as infinite");
	a_ltp_over_code: assert property (@(posedge sys_clk) disable iff (rst)
		hist_valid && !zero && db >= DBW'(LTP_OVR) |=> ltp_q == LTP_OVR)
		else $error("oversized ratio not saturated");
endmodule // fesm_ltp_enc

// *** logic/fesm_top.sv ***
// fesm_top: per-lane FEC error statistics monitor with level transition readout.
// assumes decoder counts and histogram arrive on sys_clk; registers via a plain strobe port.
`timescale 1ns/1ps
// Behaviour
// - level transition value is unsigned 16 bits in 1/256 dB steps.
// - zero valley height reports level transition as all ones.
// - finite value above 255.996 dB reports as one below all ones.
// - level transition is least of three peak-mean over valley ratios.
// - count uncorrectable frames per sampling interval as reference-size equivalents.
// - scale frame count by actual frame bits over 5440.
// - bit error ratio sample is corrected bits over received bits.
// - current sample of the last completed interval is always readable.
// - current samples update every interval, frozen or not.
// - each new sample updates running minimum, maximum and average.
// - frame error metric also accumulates its sum over the interval.
// - freeze request latches reports and restarts collection together.
// - while frozen, reported statistics hold until unfreeze or until another freeze request is taken.
// - after unfreeze, reports cover the span since the latest freeze.
// - when not frozen, live statistics are readable at any time.
// - error ratio average from accumulated corrected and received bits.
// - frame error average is accumulated count over samples taken.
// - low thresholds zero, frame error high threshold zero by default.
// - nominal sampling interval length readable in a capability field.
// - statistics only for error metrics, not level transition.
module fesm_top import fesm_pkg::*; #(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int CW = 8,
	parameter int HW = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// decoder counts
	input wire logic [CW-1:0] dec_corr_bits,
	input wire logic [CW-1:0] dec_rx_bits,
	input wire logic dec_frame_uncorr,
	// histogram
	input wire logic hist_valid,
	input wire logic [4*HW-1:0] hist_peaks,
	input wire logic [3*HW-1:0] hist_valleys,
	// status
	output logic stats_frozen
);
	function automatic logic [ACC_W-1:0] sat_add(input logic [ACC_W-1:0] a,
		input logic [ACC_W-1:0] b);
		logic [ACC_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[ACC_W] ? {ACC_W{1'b1}} : s[ACC_W-1:0];
	endfunction
	function automatic logic [RW-1:0] clip32(input logic [DIV_NW-1:0] v);
		return (v[DIV_NW-1:RW] != '0) ? {RW{1'b1}} : v[RW-1:0];
	endfunction

	fesm_div_if #(.NW(DIV_NW), .DW(ACC_W)) div_bus();
	fesm_div u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.d(div_bus)
	);
	logic [15:0] ltp_code;
	fesm_ltp_enc #(.HW(HW)) u_ltp (
		.sys_clk(sys_clk),
		.rst(rst),
		.hist_valid(hist_valid),
		.peaks(hist_peaks),
		.valleys(hist_valleys),
		.ltp_code(ltp_code)
	);

	fesm_state_e st_q;
	logic [31:0] tmr_q;
	logic tick;
	logic tick_q;
	logic take;
	logic pend_q;
	logic frozen_q;
	logic wr_ctrl;
	logic [ACC_W-1:0] corr_cnt_q, rx_cnt_q, frm_cnt_q;
	logic [ACC_W-1:0] corr_snap_q, rx_snap_q, frm_snap_q;
	logic [ACC_W-1:0] corr_acc_q, rx_acc_q, uncorrectable_frame_count_acc_q;
	logic [ACC_W-1:0] corr_acc_d, rx_acc_d, uncorrectable_frame_count_acc_d;
	logic [31:0] nsamp_q;
	logic first_q;
	logic [RW-1:0] ber_samp_q, uncorrectable_frame_count_samp_q;
	logic [RW-1:0] ber_min_q, ber_max_q, ber_avg_q;
	logic [RW-1:0] uncorrectable_frame_count_min_q, uncorrectable_frame_count_max_q, uncorrectable_frame_count_avg_q;
	logic [RW-1:0] rep_ber_min_q, rep_ber_max_q, rep_ber_avg_q;
	logic [RW-1:0] rep_uncorrectable_frame_count_min_q, rep_uncorrectable_frame_count_max_q, rep_uncorrectable_frame_count_avg_q, rep_uncorrectable_frame_count_tot_q;
	logic [15:0] frame_bits_q;
	logic [31:0] ber_thr_hi_q, uncorrectable_frame_count_thr_hi_q;
	logic start_q;
	logic [DIV_NW-1:0] num_q;
	logic [ACC_W-1:0] den_q;
	logic [31:0] rd_val;
	logic [31:0] rdata_q;

	assign div_bus.start = start_q;
	assign div_bus.num = num_q;
	assign div_bus.den = den_q;
	assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
	// freeze only between sample jobs so latched averages match min and max
	assign take = pend_q && st_q == ST_IDLE;

	// sampling interval timer
	assign tick = tmr_q == 32'(SAMPLE_CYCLES - 1);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tmr_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tmr_q <= tick ? '0 : tmr_q + 32'd1;
			tick_q <= tick;
		end
	end

	// per-interval counters; the tick cycle's counts close the interval
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			corr_cnt_q <= '0;
			rx_cnt_q <= '0;
			frm_cnt_q <= '0;
			corr_snap_q <= '0;
			rx_snap_q <= '0;
			frm_snap_q <= '0;
		end else if (tick) begin
			corr_snap_q <= sat_add(corr_cnt_q, ACC_W'(dec_corr_bits));
			rx_snap_q <= sat_add(rx_cnt_q, ACC_W'(dec_rx_bits));
			frm_snap_q <= sat_add(frm_cnt_q, ACC_W'(dec_frame_uncorr));
			corr_cnt_q <= '0;
			rx_cnt_q <= '0;
			frm_cnt_q <= '0;
		end else begin
			corr_cnt_q <= sat_add(corr_cnt_q, ACC_W'(dec_corr_bits));
			rx_cnt_q <= sat_add(rx_cnt_q, ACC_W'(dec_rx_bits));
			frm_cnt_q <= sat_add(frm_cnt_q, ACC_W'(dec_frame_uncorr));
		end
	end

	// freeze and unfreeze; the freeze being taken wins over an unfreeze written in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
			frozen_q <= 1'b0;
		end else begin
			pend_q <= (pend_q && !take) || (wr_ctrl && reg_wdata[CTRL_FREEZE]);
			frozen_q <= take || (frozen_q && !(wr_ctrl && !reg_wdata[CTRL_FREEZE]));
		end
	end

	assign corr_acc_d = sat_add(corr_acc_q, corr_snap_q);
	assign rx_acc_d = sat_add(rx_acc_q, rx_snap_q);
	assign uncorrectable_frame_count_acc_d = sat_add(uncorrectable_frame_count_acc_q, ACC_W'(uncorrectable_frame_count_samp_q));

	// sample jobs: scale frames, error ratio, statistics, two averages
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			start_q <= 1'b0;
			num_q <= '0;
			den_q <= '0;
			ber_samp_q <= '0;
			uncorrectable_frame_count_samp_q <= '0;
			ber_avg_q <= '0;
			uncorrectable_frame_count_avg_q <= '0;
		end else begin
			start_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (take) begin
						ber_avg_q <= '0;
						uncorrectable_frame_count_avg_q <= '0;
					end
					if (tick_q) begin
						st_q <= ST_FSCALE;
						start_q <= 1'b1;
						num_q <= DIV_NW'(frm_snap_q) * DIV_NW'(frame_bits_q);
						den_q <= ACC_W'(REF_FRAME_BITS);
					end
				end
				ST_FSCALE: begin
					if (div_bus.done) begin
						uncorrectable_frame_count_samp_q <= clip32(div_bus.quo);
						st_q <= ST_BSAMP;
						start_q <= 1'b1;
						num_q <= DIV_NW'(corr_snap_q) << BER_FRAC;
						den_q <= rx_snap_q;
					end
				end
				ST_BSAMP: begin
					if (div_bus.done) begin
						ber_samp_q <= (rx_snap_q == '0) ? '0 : clip32(div_bus.quo);
						st_q <= ST_UPD;
					end
				end
				ST_UPD: begin
					st_q <= ST_BAVG;
					start_q <= 1'b1;
					num_q <= DIV_NW'(corr_acc_d) << BER_FRAC;
					den_q <= rx_acc_d;
				end
				ST_BAVG: begin
					if (div_bus.done) begin
						ber_avg_q <= (rx_acc_q == '0) ? '0 : clip32(div_bus.quo);
						st_q <= ST_FAVG;
						start_q <= 1'b1;
						num_q <= DIV_NW'(uncorrectable_frame_count_acc_q) << UNCORRECTABLE_FRAME_COUNT_FRAC;
						den_q <= ACC_W'(nsamp_q);
					end
				end
				ST_FAVG: begin
					if (div_bus.done) begin
						uncorrectable_frame_count_avg_q <= clip32(div_bus.quo);
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// running statistics of the collection interval
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			first_q <= 1'b1;
			nsamp_q <= '0;
			corr_acc_q <= '0;
			rx_acc_q <= '0;
			uncorrectable_frame_count_acc_q <= '0;
			ber_min_q <= '0;
			ber_max_q <= '0;
			uncorrectable_frame_count_min_q <= '0;
			uncorrectable_frame_count_max_q <= '0;
		end else if (take) begin
			first_q <= 1'b1;
			nsamp_q <= '0;
			corr_acc_q <= '0;
			rx_acc_q <= '0;
			uncorrectable_frame_count_acc_q <= '0;
			ber_min_q <= '0;
			ber_max_q <= '0;
			uncorrectable_frame_count_min_q <= '0;
			uncorrectable_frame_count_max_q <= '0;
		end else if (st_q == ST_UPD) begin
			first_q <= 1'b0;
			nsamp_q <= (nsamp_q == '1) ? nsamp_q : nsamp_q + 32'd1;
			corr_acc_q <= corr_acc_d;
			rx_acc_q <= rx_acc_d;
			uncorrectable_frame_count_acc_q <= uncorrectable_frame_count_acc_d;
			if (first_q) begin
				ber_min_q <= ber_samp_q;
				ber_max_q <= ber_samp_q;
				uncorrectable_frame_count_min_q <= uncorrectable_frame_count_samp_q;
				uncorrectable_frame_count_max_q <= uncorrectable_frame_count_samp_q;
			end else begin
				ber_min_q <= (ber_samp_q < ber_min_q) ? ber_samp_q : ber_min_q;
				ber_max_q <= (ber_samp_q > ber_max_q) ? ber_samp_q : ber_max_q;
				uncorrectable_frame_count_min_q <= (uncorrectable_frame_count_samp_q < uncorrectable_frame_count_min_q) ? uncorrectable_frame_count_samp_q : uncorrectable_frame_count_min_q;
				uncorrectable_frame_count_max_q <= (uncorrectable_frame_count_samp_q > uncorrectable_frame_count_max_q) ? uncorrectable_frame_count_samp_q : uncorrectable_frame_count_max_q;
			end
		end
	end

	// reported statistics follow live values unless frozen
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rep_ber_min_q <= '0;
			rep_ber_max_q <= '0;
			rep_ber_avg_q <= '0;
			rep_uncorrectable_frame_count_min_q <= '0;
			rep_uncorrectable_frame_count_max_q <= '0;
			rep_uncorrectable_frame_count_avg_q <= '0;
			rep_uncorrectable_frame_count_tot_q <= '0;
		end else if (take || !frozen_q) begin
			rep_ber_min_q <= ber_min_q;
			rep_ber_max_q <= ber_max_q;
			rep_ber_avg_q <= ber_avg_q;
			rep_uncorrectable_frame_count_min_q <= uncorrectable_frame_count_min_q;
			rep_uncorrectable_frame_count_max_q <= uncorrectable_frame_count_max_q;
			rep_uncorrectable_frame_count_avg_q <= uncorrectable_frame_count_avg_q;
			rep_uncorrectable_frame_count_tot_q <= clip32(DIV_NW'(uncorrectable_frame_count_acc_q));
		end
	end

	// software-written settings
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			frame_bits_q <= REF_FRAME_BITS;
			ber_thr_hi_q <= BER_THR_HI_RST;
			uncorrectable_frame_count_thr_hi_q <= UNCORRECTABLE_FRAME_COUNT_THR_HI_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				A_FRAME_BITS: frame_bits_q <= reg_wdata[15:0];
				A_BER_THR_HI: ber_thr_hi_q <= reg_wdata;
				A_UNCORRECTABLE_FRAME_COUNT_THR_HI: uncorrectable_frame_count_thr_hi_q <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// read decode; level transition has a current value only
	always_comb begin
		case (reg_addr)
			A_CTRL: rd_val = {29'h0, st_q != ST_IDLE, frozen_q, pend_q};
			A_FRAME_BITS: rd_val = {16'h0000, frame_bits_q};
			A_INTERVAL: rd_val = 32'(SAMPLE_US);
			A_LTP: rd_val = {16'h0000, ltp_code};
			A_BER_CUR: rd_val = ber_samp_q;
			A_BER_MIN: rd_val = rep_ber_min_q;
			A_BER_MAX: rd_val = rep_ber_max_q;
			A_BER_AVG: rd_val = rep_ber_avg_q;
			A_UNCORRECTABLE_FRAME_COUNT_CUR: rd_val = uncorrectable_frame_count_samp_q;
			A_UNCORRECTABLE_FRAME_COUNT_MIN: rd_val = rep_uncorrectable_frame_count_min_q;
			A_UNCORRECTABLE_FRAME_COUNT_MAX: rd_val = rep_uncorrectable_frame_count_max_q;
			A_UNCORRECTABLE_FRAME_COUNT_AVG: rd_val = rep_uncorrectable_frame_count_avg_q;
			A_UNCORRECTABLE_FRAME_COUNT_TOT: rd_val = rep_uncorrectable_frame_count_tot_q;
			A_BER_THR_HI: rd_val = ber_thr_hi_q;
			A_UNCORRECTABLE_FRAME_COUNT_THR_HI: rd_val = uncorrectable_frame_count_thr_hi_q;
			A_BER_THR_LO: rd_val = THR_LO;
			A_UNCORRECTABLE_FRAME_COUNT_THR_LO: rd_val = THR_LO;
			default: rd_val = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_val : '0;
		end
	end
	assign reg_rdata = rdata_q;
	assign stats_frozen = frozen_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_freeze_taken;
		pend_q && st_q == ST_IDLE;
	endsequence
	sequence s_first_update;
		st_q == ST_UPD && first_q;
	endsequence

	a_tick_reaches_update: assert property ((tick && frozen_q) |-> ##[1:200] st_q == ST_UPD)
		else $error("frozen interval did not update samples");
	a_freeze_restart: assert property (s_freeze_taken |=>
		nsamp_q == 0 && first_q && uncorrectable_frame_count_acc_q == 0 && frozen_q)
		else $error("freeze did not restart collection");
	a_frozen_hold: assert property (frozen_q && !take |=>
		$stable(rep_uncorrectable_frame_count_tot_q) && $stable(rep_ber_max_q) && $stable(rep_ber_avg_q))
		else $error("frozen report changed");
	a_live_follow: assert property (!frozen_q ##1 !frozen_q |->
		rep_ber_avg_q == $past(ber_avg_q) && rep_uncorrectable_frame_count_min_q == $past(uncorrectable_frame_count_min_q))
		else $error("live report lags statistics");
	a_first_seeds: assert property (s_first_update |=>
		ber_min_q == $past(ber_samp_q) && uncorrectable_frame_count_max_q == $past(uncorrectable_frame_count_samp_q))
		else $error("first sample did not seed min and max");
	a_minmax_order: assert property (st_q == ST_UPD && !first_q && !take |=>
		ber_min_q <= $past(ber_samp_q) && ber_max_q >= $past(ber_samp_q) && ber_min_q <= ber_max_q)
		else $error("min or max not updated");
	a_total_count: assert property (st_q == ST_UPD && !take |=>
		nsamp_q == $past(nsamp_q) + 1 && uncorrectable_frame_count_acc_q >= $past(uncorrectable_frame_count_acc_q))
		else $error("frame total or count not advanced");
	a_ltp_read: assert property (reg_rd && reg_addr == A_LTP |=>
		reg_rdata == {16'h0000, $past(ltp_code)} ##1 reg_rdata == 0 || $past(reg_rd))
		else $error("level transition read wrong");
endmodule // fesm_top

// *** test/fesm_host.sv ***
// fesm_host: host management controller model on the register strobe port.
// assumes read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps
module fesm_host (
	// clock
	input wire logic sys_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// freeze and unfreeze requests go through here
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// idle bus shows inverted values, not a stale copy
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule // fesm_host

// *** test/tb.sv ***
// tb: self-checking bench of the FEC error statistics monitor.
// assumes the host model drives the register port; bench drives decoder and histogram.
`timescale 1ns/1ps
module tb import fesm_pkg::*; ;
	localparam int SMP = 400;
	localparam int FPI = SMP / 8;
	typedef struct {
		logic [63:0] p;
		logic [47:0] q;
		logic [15:0] ltp;
	} fesm_row_s;
	logic sys_clk;
	logic rst;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [7:0] dec_corr_bits;
	logic [7:0] dec_rx_bits;
	logic dec_frame_uncorr;
	logic hist_valid;
	logic [63:0] hist_peaks;
	logic [47:0] hist_valleys;
	logic stats_frozen;
	logic [7:0] corr_v;
	logic [31:0] cyc_q = 32'h0000_0000;
	logic [31:0] v;
	logic [31:0] held;
	int mismatches = 0;
	int n_tests = 0;
	fesm_row_s rows [5] = '{
		'{64'h00C8_00C8_00C8_00C8, 48'h0032_0032_0064, DB_PER_LOG2},
		'{64'h0320_0320_0320_0320, 48'h00C8_0064_0064, DB_PER_LOG2 << 1},
		'{64'h0190_0190_0190_0190, 48'h0064_0000_0064, LTP_INF},
		'{64'h000A_000A_000A_000A, 48'h0028_0028_0028, 16'h0000},
		'{64'h0320_0320_0320_0320, 48'h0064_0064_0064, 16'(DB_PER_LOG2 * 3)}
	};
	logic [7:0] ra [8] = '{A_CTRL, A_FRAME_BITS, A_INTERVAL, A_BER_THR_HI,
		A_UNCORRECTABLE_FRAME_COUNT_THR_HI, A_BER_THR_LO, A_UNCORRECTABLE_FRAME_COUNT_THR_LO, 8'h20};
	logic [31:0] re [8] = '{32'h0000_0000, {16'h0000, REF_FRAME_BITS}, 32'h0000_03E8,
		BER_THR_HI_RST, UNCORRECTABLE_FRAME_COUNT_THR_HI_RST, THR_LO, THR_LO, 32'h0000_0000};

	fesm_top #(.SAMPLE_CYCLES(SMP)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dec_corr_bits(dec_corr_bits), .dec_rx_bits(dec_rx_bits),
		.dec_frame_uncorr(dec_frame_uncorr), .hist_valid(hist_valid),
		.hist_peaks(hist_peaks), .hist_valleys(hist_valleys), .stats_frozen(stats_frozen)
	);
	fesm_host host_u (
		.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// one frame every 8 cycles: any whole interval holds exactly SMP/8
	always @(posedge sys_clk) begin
		cyc_q <= cyc_q + 32'h0000_0001;
		dec_frame_uncorr <= (cyc_q[2:0] == 3'h0);
		dec_corr_bits <= corr_v;
		dec_rx_bits <= 8'h80;
	end

	task results();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		host_u.rd(a, v);
		chk(nm, e, v);
	endtask
	task hist(input logic [63:0] p, input logic [47:0] q);
		@(posedge sys_clk);
		hist_valid <= 1'b1;
		hist_peaks <= p;
		hist_valleys <= q;
		@(posedge sys_clk);
		hist_valid <= 1'b0;
	endtask
	task wait_busy(input logic lvl);
		for (int k = 0; k < 1000; k++) begin
			host_u.rd(A_CTRL, v);
			if (v[CTRL_BUSY] === lvl) return;
		end
		mismatches++;
		$display("[ERR] busy wait expected %b seen timeout", lvl);
		results();
	endtask
	// one whole statistics job finished
	task wait_job();
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask

	initial begin
		rst = 1'b1;
		corr_v = 8'h01;
		dec_corr_bits = 8'h00;
		dec_rx_bits = 8'h00;
		dec_frame_uncorr = 1'b0;
		hist_valid = 1'b0;
		hist_peaks = 64'h0000_0000_0000_0000;
		hist_valleys = 48'h0000_0000_0000;
		repeat (8) @(posedge sys_clk);
		chk("frozen_rst", 32'h0000_0000, {31'h0, stats_frozen});
		chk("rdata_rst", 32'h0000_0000, reg_rdata);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			hist(rows[i].p, rows[i].q);
			rchk("ltp", A_LTP, {16'h0000, rows[i].ltp});
		end
		host_u.wr(A_BER_THR_LO, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) begin
			rchk("reset_reg", ra[i], re[i]);
		end
		wait_job();
		rchk("ber_cur", A_BER_CUR, 32'h0000_0001 << 25);
		rchk("ber_avg", A_BER_AVG, 32'h0000_0001 << 25);
		rchk("uncorrectable_frame_count_cur", A_UNCORRECTABLE_FRAME_COUNT_CUR, FPI);
		host_u.wr(A_FRAME_BITS, {16'h0000, REF_FRAME_BITS << 1});
		wait_job();
		rchk("uncorrectable_frame_count_scaled", A_UNCORRECTABLE_FRAME_COUNT_CUR, 2 * FPI);
		host_u.wr(A_FRAME_BITS, {16'h0000, REF_FRAME_BITS});
		wait_job();
		host_u.wr(A_CTRL, 32'h0000_0001);
		corr_v <= 8'h02;
		rchk("ctrl_frozen", A_CTRL, 32'h0000_0002);
		chk("frozen_pin", 32'h0000_0001, {31'h0, stats_frozen});
		rchk("tot_frz", A_UNCORRECTABLE_FRAME_COUNT_TOT, 4 * FPI);
		rchk("max_frz", A_UNCORRECTABLE_FRAME_COUNT_MAX, 2 * FPI);
		rchk("min_frz", A_UNCORRECTABLE_FRAME_COUNT_MIN, FPI);
		wait_job();
		wait_job();
		rchk("tot_hold", A_UNCORRECTABLE_FRAME_COUNT_TOT, 4 * FPI);
		rchk("max_hold", A_UNCORRECTABLE_FRAME_COUNT_MAX, 2 * FPI);
		rchk("ber_cur_frz", A_BER_CUR, 32'h0000_0001 << 26);
		host_u.wr(A_CTRL, 32'h0000_0000);
		#1;
		chk("unfrozen_pin", 32'h0000_0000, {31'h0, stats_frozen});
		rchk("tot_live", A_UNCORRECTABLE_FRAME_COUNT_TOT, 2 * FPI);
		rchk("min_live", A_UNCORRECTABLE_FRAME_COUNT_MIN, FPI);
		rchk("max_live", A_UNCORRECTABLE_FRAME_COUNT_MAX, FPI);
		rchk("avg_live", A_UNCORRECTABLE_FRAME_COUNT_AVG, FPI << UNCORRECTABLE_FRAME_COUNT_FRAC);
		rchk("ber_max", A_BER_MAX, 32'h0000_0001 << 26);
		results();
	end
endmodule // tb
